// ---- design/slr_pkg.sv ----
package slr_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_SLEEP_CTL = 8'h53;
    localparam logic [7:0] OFF_GATE_ZERO = 8'h64;
    localparam logic [7:0] OFF_LEAK_CTL = 8'h70;
    localparam logic [7:0] OFF_TRIM_LOW = 8'h71;
    localparam logic [7:0] OFF_TRIM_HIGH = 8'h72;

    localparam logic [7:0] RST_SLEEP_CTL = 8'h00;
    localparam logic [7:0] RST_GATE_ZERO = 8'h00;
    localparam logic [7:0] RST_TRIM_LOW = 8'h00;
    localparam logic [7:0] RST_TRIM_HIGH = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Leak regulator control fields
    localparam int BIT_CAL_ENABLE = 0;
    localparam int BIT_TEMP_COEFF = 1;
    localparam int BIT_BYPASS_SHORT = 2;
    localparam int BIT_CAL_SYNC_BUSY = 3;
    localparam int BIT_CAL_DONE = 4;

    // Sleep control fields
    localparam int BIT_SLEEP_ARM = 0;
    localparam int LSB_SLEEP_SEL = 1;
    localparam int MSB_SLEEP_SEL = 3;

    // Power gate zero fields
    localparam int BIT_GATE_CONVERTER = 0;
    localparam int BIT_GATE_PORT_ZERO = 1;
    localparam int BIT_GATE_SERIAL = 2;
    localparam int BIT_GATE_TIMER_ONE = 3;
    localparam int BIT_AMP_REDUCE = 4;
    localparam int BIT_GATE_TIMER_ZERO = 5;
    localparam int BIT_GATE_TIMER_TWO = 6;
    localparam int BIT_GATE_TWO_WIRE = 7;

    typedef enum logic [2:0] {
        SEL_IDLE = 3'h0,
        SEL_NOISE_REDUCE = 3'h1,
        SEL_POWER_DOWN = 3'h2,
        SEL_POWER_SAVE = 3'h3,
        SEL_RESERVED_A = 3'h4,
        SEL_RESERVED_B = 3'h5,
        SEL_STANDBY = 3'h6,
        SEL_EXT_STANDBY = 3'h7
    } slr_sleep_sel_t;

    typedef enum logic [2:0] {
        ST_ACTIVE = 3'b000,
        ST_LIGHT = 3'b001,
        ST_DEEP_WAIT = 3'b010,
        ST_DEEP = 3'b011,
        ST_WAKE_DLY = 3'b100
    } slr_state_t;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CORE_HZ = 20000000;
    localparam int OSC_HZ = 128000;
    localparam int OSC_DIV = CORE_HZ / OSC_HZ;
    localparam logic [7:0] OSC_DIV_LAST = 8'(OSC_DIV - 1);
    localparam logic [2:0] WAKE_OSC_CYCLES = 3'h4;
    localparam logic [1:0] SYNC_SLOW_CYCLES = 2'h2;
    localparam logic [7:0] CAL_SLOW_CYCLES = 8'h10;

endpackage

// ---- design/slr_sleep_power_ctrl.sv ----
`timescale 1ns/1ps
// Contract
// - Deep sleep: main regulator off, leak regulator holds.
// - Calibrate leak regulator while awake, apply stored.
// - Fresh calibration after every deep sleep wake.
// - Chain stays on until one calibration completes; with calibration disabled it drops without waiting.
// - Calibration starts four oscillator cycles after wake.
// - Disabled calibration settles within five slow cycles.
// - Auto calibration at power-up; done flag on completion.
// - Calibration continues until deep sleep or disable.
// - Sleep voltage from trims, temp and short bits.
// - Control and trim writes only when calibration disabled, except the enable bit.
// - Larger trim value gives lower sleep voltage.
// - Written values reach regulator after two slow cycles.
// - High trim write needs following low trim write.
// - Control bit 3 shows sync or calibration busy.
// - Sleep select encoding, codes four and five reserved.
// - Sleep instruction acts only with sleep arm set.
// - Power gate bits stop their peripherals, reset zero.
// - Ungated timer resumes exactly where it stopped.
// - Sleep control upper nibble reads zero, resets zero.
// - Chain stays on unless radio is off or asleep.
module slr_sleep_power_ctrl
(
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    output logic [7:0] RDATA,
    input wire logic SLEEP_INSTR,
    input wire logic WAKE_REQ,
    input wire logic RADIO_OFF,
    input wire logic CAL_CMP_HIGH,
    output logic CPU_SLEEP,
    output logic POWER_CHAIN_EN,
    output logic MAIN_REG_EN,
    output logic LEAK_REG_HOLD,
    output logic [7:0] LEAK_TRIM_LOW,
    output logic [7:0] LEAK_TRIM_HIGH,
    output logic LEAK_TCO,
    output logic LEAK_SHORT,
    output logic GATE_TWO_WIRE,
    output logic GATE_TIMER_TWO,
    output logic GATE_TIMER_ZERO,
    output logic AMP_CURRENT_REDUCE,
    output logic GATE_TIMER_ONE,
    output logic GATE_SERIAL_PERIPH,
    output logic GATE_SERIAL_PORT_ZERO,
    output logic GATE_CONVERTER
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic wake_s;
    logic radio_off_s;
    logic cmp_high_s;

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
        end
        else
        begin
            sync_a <= {CAL_CMP_HIGH, RADIO_OFF, WAKE_REQ};
            sync_b <= sync_a;
        end
    end

    assign wake_s = sync_b[0];
    assign radio_off_s = sync_b[1];
    assign cmp_high_s = sync_b[2];

    // ------------------------------------------------------------
    // Oscillator and slow clock ticks
    // ------------------------------------------------------------
    // The regulator logic is modelled as tick-qualified logic on the
    // core clock; a 20 MHz core is far above the slow rate.
    logic [7:0] osc_cnt;
    logic osc_half;
    logic osc_tick;
    logic slow_tick;

    assign osc_tick = (osc_cnt == slr_pkg::OSC_DIV_LAST);
    assign slow_tick = osc_tick & osc_half;

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            osc_cnt <= 8'h00;
            osc_half <= 1'b0;
        end
        else
        begin
            osc_cnt <= osc_tick ? 8'h00 : osc_cnt + 8'h01;
            osc_half <= osc_tick ? ~osc_half : osc_half;
        end
    end

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    logic [7:0] sleep_ctl_reg;
    logic [7:0] power_gate_reg_zero;
    logic cal_enable_bit;
    logic temp_coeff_bit;
    logic bypass_short_bit;
    logic cal_done_flag;
    logic cal_sync_busy;
    logic [7:0] leak_trim_low;
    logic [7:0] leak_trim_high;
    logic [7:0] pend_high;
    logic pend_high_valid;

    wire wr_sleep = WR_STB && (ADDR == slr_pkg::OFF_SLEEP_CTL);
    wire wr_gate = WR_STB && (ADDR == slr_pkg::OFF_GATE_ZERO);
    wire wr_ctl = WR_STB && (ADDR == slr_pkg::OFF_LEAK_CTL);
    wire wr_low = WR_STB && (ADDR == slr_pkg::OFF_TRIM_LOW);
    wire wr_high = WR_STB && (ADDR == slr_pkg::OFF_TRIM_HIGH);
    wire sw_open = ~cal_enable_bit;
    wire commit_low = wr_low && sw_open;
    wire commit_high = commit_low && pend_high_valid;

    wire [7:0] ctl_view = {3'h0, cal_done_flag, cal_sync_busy, bypass_short_bit,
                           temp_coeff_bit, cal_enable_bit};
    wire [7:0] rd_mux =
        (ADDR == slr_pkg::OFF_SLEEP_CTL) ? {4'h0, sleep_ctl_reg[3:0]} :
        (ADDR == slr_pkg::OFF_GATE_ZERO) ? power_gate_reg_zero :
        (ADDR == slr_pkg::OFF_LEAK_CTL) ? ctl_view :
        (ADDR == slr_pkg::OFF_TRIM_LOW) ? leak_trim_low :
        (ADDR == slr_pkg::OFF_TRIM_HIGH) ? leak_trim_high :
        slr_pkg::READ_UNMAPPED;

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
            RDATA <= 8'h00;
        else if (RD_STB)
            RDATA <= rd_mux;
    end

    // ------------------------------------------------------------
    // Sleep control and power gate registers
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            sleep_ctl_reg <= slr_pkg::RST_SLEEP_CTL;
            power_gate_reg_zero <= slr_pkg::RST_GATE_ZERO;
        end
        else
        begin
            if (wr_sleep)
                sleep_ctl_reg <= {4'h0, WDATA[3:0]};
            if (wr_gate)
                power_gate_reg_zero <= WDATA;
        end
    end

    // Gating only stops the clock or current; timer state is kept
    assign GATE_TWO_WIRE = power_gate_reg_zero[slr_pkg::BIT_GATE_TWO_WIRE];
    assign GATE_TIMER_TWO = power_gate_reg_zero[slr_pkg::BIT_GATE_TIMER_TWO];
    assign GATE_TIMER_ZERO = power_gate_reg_zero[slr_pkg::BIT_GATE_TIMER_ZERO];
    assign AMP_CURRENT_REDUCE = power_gate_reg_zero[slr_pkg::BIT_AMP_REDUCE];
    assign GATE_TIMER_ONE = power_gate_reg_zero[slr_pkg::BIT_GATE_TIMER_ONE];
    assign GATE_SERIAL_PERIPH = power_gate_reg_zero[slr_pkg::BIT_GATE_SERIAL];
    assign GATE_SERIAL_PORT_ZERO = power_gate_reg_zero[slr_pkg::BIT_GATE_PORT_ZERO];
    assign GATE_CONVERTER = power_gate_reg_zero[slr_pkg::BIT_GATE_CONVERTER];

    // ------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------
    slr_pkg::slr_state_t state;
    slr_pkg::slr_state_t next_state;
    logic first_cal_done;
    logic [2:0] wake_cnt;

    wire sleep_arm = sleep_ctl_reg[slr_pkg::BIT_SLEEP_ARM];
    wire [2:0] sleep_select = sleep_ctl_reg[slr_pkg::MSB_SLEEP_SEL:slr_pkg::LSB_SLEEP_SEL];
    wire sel_deep = (sleep_select == slr_pkg::SEL_POWER_DOWN) ||
                    (sleep_select == slr_pkg::SEL_POWER_SAVE);
    wire sel_reserved = (sleep_select == slr_pkg::SEL_RESERVED_A) ||
                        (sleep_select == slr_pkg::SEL_RESERVED_B);
    wire go_sleep = SLEEP_INSTR && sleep_arm && !sel_reserved;
    // Disabled calibration means software owns the trims, so no wait
    wire cal_ok = first_cal_done || !cal_enable_bit;
    wire wake_dly_done = (wake_cnt == slr_pkg::WAKE_OSC_CYCLES);
    wire deep_entry = (state == slr_pkg::ST_DEEP_WAIT) && (next_state == slr_pkg::ST_DEEP);

    always_comb
    begin
        next_state = state;
        case (state)
            slr_pkg::ST_ACTIVE, slr_pkg::ST_WAKE_DLY:
            begin
                if (go_sleep)
                    next_state = sel_deep ? slr_pkg::ST_DEEP_WAIT : slr_pkg::ST_LIGHT;
                else if (state == slr_pkg::ST_WAKE_DLY && wake_dly_done)
                    next_state = slr_pkg::ST_ACTIVE;
            end
            slr_pkg::ST_LIGHT:
            begin
                if (wake_s)
                    next_state = slr_pkg::ST_ACTIVE;
            end
            slr_pkg::ST_DEEP_WAIT:
            begin
                if (wake_s)
                    next_state = slr_pkg::ST_ACTIVE;
                else if (cal_ok && radio_off_s)
                    next_state = slr_pkg::ST_DEEP;
            end
            slr_pkg::ST_DEEP:
            begin
                if (wake_s)
                    next_state = slr_pkg::ST_WAKE_DLY;
            end
            default:
                next_state = slr_pkg::ST_ACTIVE;
        endcase
    end

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            state <= slr_pkg::ST_ACTIVE;
            wake_cnt <= 3'h0;
        end
        else
        begin
            state <= next_state;
            if (state != slr_pkg::ST_WAKE_DLY)
                wake_cnt <= 3'h0;
            else if (osc_tick && !wake_dly_done)
                wake_cnt <= wake_cnt + 3'h1;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            CPU_SLEEP <= 1'b0;
            POWER_CHAIN_EN <= 1'b1;
            MAIN_REG_EN <= 1'b1;
            LEAK_REG_HOLD <= 1'b0;
        end
        else
        begin
            CPU_SLEEP <= (next_state == slr_pkg::ST_LIGHT) ||
                         (next_state == slr_pkg::ST_DEEP_WAIT) ||
                         (next_state == slr_pkg::ST_DEEP);
            POWER_CHAIN_EN <= (next_state != slr_pkg::ST_DEEP);
            MAIN_REG_EN <= (next_state != slr_pkg::ST_DEEP);
            LEAK_REG_HOLD <= (next_state == slr_pkg::ST_DEEP);
        end
    end

    // ------------------------------------------------------------
    // Calibration engine
    // ------------------------------------------------------------
    logic cal_on;
    logic start_req;
    logic [7:0] cal_cnt;

    wire awake = (state == slr_pkg::ST_ACTIVE) || (state == slr_pkg::ST_LIGHT) ||
                 (state == slr_pkg::ST_DEEP_WAIT);
    wire cal_halt = !cal_enable_bit || (state == slr_pkg::ST_DEEP) || deep_entry;
    wire cal_begin = start_req && cal_enable_bit && awake && slow_tick;
    wire cal_step = cal_on && !cal_halt && slow_tick;
    wire cal_last = (cal_cnt == slr_pkg::CAL_SLOW_CYCLES - 8'h01);
    wire [15:0] trim_now = {leak_trim_high, leak_trim_low};
    // Output above main level: raise trim, which lowers the voltage
    wire [15:0] trim_up = (trim_now == 16'hFFFF) ? trim_now : trim_now + 16'h0001;
    wire [15:0] trim_dn = (trim_now == 16'h0000) ? trim_now : trim_now - 16'h0001;
    wire [15:0] trim_cal = cmp_high_s ? trim_up : trim_dn;

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            start_req <= 1'b1;
            cal_on <= 1'b0;
            cal_cnt <= 8'h00;
            cal_done_flag <= 1'b0;
            first_cal_done <= 1'b0;
        end
        else
        begin
            if (state == slr_pkg::ST_WAKE_DLY && wake_dly_done)
                start_req <= 1'b1;
            else if (cal_begin)
                start_req <= 1'b0;
            if (cal_halt)
                cal_on <= 1'b0;
            else if (cal_begin)
                cal_on <= 1'b1;
            if (cal_begin)
                cal_cnt <= 8'h00;
            else if (cal_step)
                cal_cnt <= cal_last ? 8'h00 : cal_cnt + 8'h01;
            if (cal_step && cal_last)
                cal_done_flag <= 1'b1;
            else if (cal_begin)
                cal_done_flag <= 1'b0;
            if (cal_step && cal_last)
                first_cal_done <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Control and trim registers
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            cal_enable_bit <= 1'b1;
            temp_coeff_bit <= 1'b0;
            bypass_short_bit <= 1'b0;
            leak_trim_low <= slr_pkg::RST_TRIM_LOW;
            leak_trim_high <= slr_pkg::RST_TRIM_HIGH;
            pend_high <= 8'h00;
            pend_high_valid <= 1'b0;
        end
        else
        begin
            if (wr_ctl)
                cal_enable_bit <= WDATA[slr_pkg::BIT_CAL_ENABLE];
            if (wr_ctl && sw_open)
            begin
                temp_coeff_bit <= WDATA[slr_pkg::BIT_TEMP_COEFF];
                bypass_short_bit <= WDATA[slr_pkg::BIT_BYPASS_SHORT];
            end
            if (wr_high && sw_open)
                pend_high <= WDATA;
            if (wr_high && sw_open)
                pend_high_valid <= 1'b1;
            else if (wr_ctl || wr_low)
                pend_high_valid <= 1'b0;
            if (commit_low)
                leak_trim_low <= WDATA;
            else if (cal_step)
                leak_trim_low <= trim_cal[7:0];
            if (commit_high)
                leak_trim_high <= pend_high;
            else if (cal_step)
                leak_trim_high <= trim_cal[15:8];
        end
    end

    // ------------------------------------------------------------
    // Transfer to the regulator
    // ------------------------------------------------------------
    // Two slow stages give the crossing delay; a restart-on-change counter
    // would starve the outputs while calibration steps every slow tick.
    // Deep entry applies the stored result at once and then freezes it.
    logic sync_pend;
    logic [1:0] sync_cnt;
    logic [17:0] stage_a;
    logic [17:0] stage_b;

    wire [17:0] leak_now = {bypass_short_bit, temp_coeff_bit, leak_trim_high, leak_trim_low};
    wire vis_change = commit_low || cal_step ||
                      (wr_ctl && (sw_open || WDATA[slr_pkg::BIT_CAL_ENABLE] != cal_enable_bit));
    wire sync_fire = sync_pend && slow_tick && (sync_cnt == slr_pkg::SYNC_SLOW_CYCLES);

    assign cal_sync_busy = sync_pend || cal_on || start_req && cal_enable_bit;

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            sync_pend <= 1'b1;
            sync_cnt <= 2'h0;
        end
        else if (vis_change)
        begin
            sync_pend <= 1'b1;
            sync_cnt <= 2'h0;
        end
        else if (sync_fire)
            sync_pend <= 1'b0;
        else if (sync_pend && slow_tick)
            sync_cnt <= sync_cnt + 2'h1;
    end

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            stage_a <= {2'h0, slr_pkg::RST_TRIM_HIGH, slr_pkg::RST_TRIM_LOW};
            stage_b <= {2'h0, slr_pkg::RST_TRIM_HIGH, slr_pkg::RST_TRIM_LOW};
        end
        else if (slow_tick)
        begin
            stage_a <= leak_now;
            stage_b <= stage_a;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            LEAK_TRIM_LOW <= slr_pkg::RST_TRIM_LOW;
            LEAK_TRIM_HIGH <= slr_pkg::RST_TRIM_HIGH;
            LEAK_TCO <= 1'b0;
            LEAK_SHORT <= 1'b0;
        end
        else if (deep_entry)
            {LEAK_SHORT, LEAK_TCO, LEAK_TRIM_HIGH, LEAK_TRIM_LOW} <= leak_now;
        else if (slow_tick && state != slr_pkg::ST_DEEP)
            {LEAK_SHORT, LEAK_TCO, LEAK_TRIM_HIGH, LEAK_TRIM_LOW} <= stage_b;
    end

endmodule

// ---- tb/slr_sleep_power_ctrl_assertions.sv ----
`timescale 1ns/1ps
module slr_spc_assertions
(
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    input wire logic [7:0] RDATA,
    input wire logic SLEEP_INSTR,
    input wire logic WAKE_REQ,
    input wire logic RADIO_OFF,
    input wire logic CPU_SLEEP,
    input wire logic POWER_CHAIN_EN,
    input wire logic MAIN_REG_EN,
    input wire logic LEAK_REG_HOLD,
    input wire logic [7:0] LEAK_TRIM_LOW,
    input wire logic [7:0] LEAK_TRIM_HIGH,
    input wire logic GATE_TWO_WIRE,
    input wire logic GATE_CONVERTER
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);

    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    // Wake must pass the two-stage synchroniser before it counts
    sequence s_wake_held;
        CPU_SLEEP && WAKE_REQ ##1 WAKE_REQ [*3];
    endsequence

    sequence s_deep_settled;
        LEAK_REG_HOLD ##1 LEAK_REG_HOLD;
    endsequence

    a_main_tracks_chain: assert property (MAIN_REG_EN == POWER_CHAIN_EN)
        else $error("main regulator enable differs from chain enable");
    a_leak_holds_deep: assert property (!POWER_CHAIN_EN |-> LEAK_REG_HOLD && CPU_SLEEP)
        else $error("chain off without leak regulator hold");
    a_chain_needs_radio: assert property ($fell(POWER_CHAIN_EN) |-> $past(RADIO_OFF, 3))
        else $error("chain dropped while radio active");
    a_sleep_needs_cmd: assert property ($rose(CPU_SLEEP) |-> $past(SLEEP_INSTR))
        else $error("sleep entered without sleep instruction");
    a_wake_resumes: assert property (s_wake_held |-> ##[0:2] (!CPU_SLEEP && POWER_CHAIN_EN))
        else $error("wake did not restore power");
    a_trims_frozen: assert property (s_deep_settled |->
        $stable(LEAK_TRIM_LOW) && $stable(LEAK_TRIM_HIGH))
        else $error("trims moved during deep sleep");
    a_sleep_ctl_upper: assert property (RD_STB && ADDR == slr_pkg::OFF_SLEEP_CTL |=>
        RDATA[7:4] == 4'h0)
        else $error("sleep control upper nibble not zero");
    a_gate_write: assert property (WR_STB && ADDR == slr_pkg::OFF_GATE_ZERO |=>
        GATE_TWO_WIRE == $past(WDATA[7]) && GATE_CONVERTER == $past(WDATA[0]))
        else $error("gate outputs do not follow write");
endmodule

// ---- tb/slr_sleep_power_ctrl_bench.sv ----
`timescale 1ns/1ps
module slr_sleep_power_ctrl_bench;
    logic clk, rst, wr_stb, rd_stb, sleep_instr, wake_req, radio_off, cmp_high;
    logic [7:0] addr, wdata, rdata, trim_low, trim_high, v, tl, th;
    wire [7:0] gates;
    logic cpu_sleep, chain_en, main_en, leak_hold, tco, short_bit;
    int miscompares = 0;
    int checked = 0;

    slr_sleep_power_ctrl DUT (.CORE_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
        .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata), .SLEEP_INSTR(sleep_instr),
        .WAKE_REQ(wake_req), .RADIO_OFF(radio_off), .CAL_CMP_HIGH(cmp_high),
        .CPU_SLEEP(cpu_sleep), .POWER_CHAIN_EN(chain_en), .MAIN_REG_EN(main_en),
        .LEAK_REG_HOLD(leak_hold), .LEAK_TRIM_LOW(trim_low), .LEAK_TRIM_HIGH(trim_high),
        .LEAK_TCO(tco), .LEAK_SHORT(short_bit), .GATE_TWO_WIRE(gates[7]),
        .GATE_TIMER_TWO(gates[6]), .GATE_TIMER_ZERO(gates[5]), .AMP_CURRENT_REDUCE(gates[4]),
        .GATE_TIMER_ONE(gates[3]), .GATE_SERIAL_PERIPH(gates[2]),
        .GATE_SERIAL_PORT_ZERO(gates[1]), .GATE_CONVERTER(gates[0]));

    initial
    begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------
    // Strobes drop one edge before the next task raises them again
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'h1;
        @(posedge clk);
        wr_stb <= 1'h0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'h1;
        @(posedge clk);
        rd_stb <= 1'h0;
        #1;
        d = rdata;
    endtask

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic poll(input int b, input logic val, input int lim, input string n);
        int k;
        k = 0;
        v = {8{~val}};
        while (v[b] !== val && k < lim)
        begin
            rd(slr_pkg::OFF_LEAK_CTL, v);
            k++;
        end
        chk(n, {7'h0, val}, {7'h0, v[b]});
    endtask

    task automatic spulse(input logic e);
        @(posedge clk);
        sleep_instr <= 1'h1;
        @(posedge clk);
        sleep_instr <= 1'h0;
        repeat (3) @(posedge clk);
        #1;
        chk("cpu_sleep", {7'h0, e}, {7'h0, cpu_sleep});
    endtask

    task automatic deep_off();
        int k;
        k = 0;
        while (chain_en !== 1'h0 && k < 20)
        begin
            @(posedge clk);
            k++;
        end
        #1;
        chk("chain_hold_main", 8'h02, {5'h0, chain_en, leak_hold, main_en});
    endtask

    task automatic wake();
        @(posedge clk);
        wake_req <= 1'h1;
        repeat (5) @(posedge clk);
        #1;
        chk("awake_chain", 8'h01, {6'h0, cpu_sleep, chain_en});
        @(posedge clk);
        wake_req <= 1'h0;
        wr(slr_pkg::OFF_SLEEP_CTL, 8'h00);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(slr_pkg::OFF_LEAK_CTL, v);
        chk("leak_ctl", 8'h09, v);
        rd(slr_pkg::OFF_SLEEP_CTL, v);
        chk("sleep_ctl", 8'h00, v);
        rd(slr_pkg::OFF_GATE_ZERO, v);
        chk("gate_reg", 8'h00, v);
        rd(8'h10, v);
        chk("unmapped", 8'h00, v);
        chk("gate_out", 8'h00, gates);
    endtask

    task automatic t_deep();
        radio_off <= 1'h1;
        wr(slr_pkg::OFF_SLEEP_CTL, 8'h05);
        spulse(1'h1);
        repeat (20) @(posedge clk);
        #1;
        chk("chain_before_cal", 8'h01, {7'h0, chain_en});
        wake();
        poll(4, 1'h1, 6000, "cal_done");
        {th, tl} = {trim_high, trim_low};
        repeat (700) @(posedge clk);
        #1;
        chk("cal_steps_up", 8'h01, {7'h0, {trim_high, trim_low} > {th, tl}});
        wr(slr_pkg::OFF_SLEEP_CTL, 8'h05);
        spulse(1'h1);
        deep_off();
        {th, tl} = {trim_high, trim_low};
        wake();
        wr(slr_pkg::OFF_SLEEP_CTL, 8'h07);
        spulse(1'h1);
        deep_off();
        chk("old_trim_low", tl, trim_low);
        chk("old_trim_high", th, trim_high);
        wake();
        repeat (1000) @(posedge clk);
        rd(slr_pkg::OFF_LEAK_CTL, v);
        chk("fresh_cal", 8'h08, v & 8'h18);
        radio_off <= 1'h0;
    endtask

    task automatic t_select();
        wr(slr_pkg::OFF_SLEEP_CTL, 8'hFF);
        rd(slr_pkg::OFF_SLEEP_CTL, v);
        chk("sleep_ctl_ro", 8'h0F, v);
        wr(slr_pkg::OFF_SLEEP_CTL, 8'h04);
        spulse(1'h0);
        for (int c = 0; c < 8; c++)
        begin
            wr(slr_pkg::OFF_SLEEP_CTL, {4'h0, 3'(c), 1'h1});
            spulse(c != 4 && c != 5);
            chk("chain_radio_on", 8'h01, {7'h0, chain_en});
            if (c != 4 && c != 5)
                wake();
        end
    endtask

    task automatic t_gates();
        for (int i = 0; i < 8; i++)
        begin
            wr(slr_pkg::OFF_GATE_ZERO, 8'h01 << i);
            chk("gate_out", 8'h01 << i, gates);
            rd(slr_pkg::OFF_GATE_ZERO, v);
            chk("gate_reg", 8'h01 << i, v);
        end
        wr(slr_pkg::OFF_GATE_ZERO, 8'h00);
    endtask

    task automatic t_trims();
        wr(slr_pkg::OFF_LEAK_CTL, 8'h00);
        poll(3, 1'h0, 800, "disable_settle");
        th = trim_high;
        wr(slr_pkg::OFF_TRIM_HIGH, 8'h0F);
        wr(slr_pkg::OFF_TRIM_LOW, 8'h06);
        wr(slr_pkg::OFF_LEAK_CTL, 8'h06);
        repeat (250) @(posedge clk);
        #1;
        chk("trim_late", th, trim_high);
        poll(3, 1'h0, 800, "sync_busy");
        chk("trims_out", 8'hF6, {trim_high[3:0], trim_low[3:0]});
        chk("tco_short", 8'h03, {6'h0, tco, short_bit});
        wr(slr_pkg::OFF_TRIM_HIGH, 8'h20);
        wr(slr_pkg::OFF_LEAK_CTL, 8'h06);
        poll(3, 1'h0, 800, "sync_busy");
        rd(slr_pkg::OFF_TRIM_HIGH, v);
        chk("orphan_high", 8'h0F, v);
        wr(slr_pkg::OFF_TRIM_LOW, 8'h07);
        poll(3, 1'h0, 800, "sync_busy");
        chk("low_only", 8'h07, trim_low);
        chk("high_kept", 8'h0F, trim_high);
        wr(slr_pkg::OFF_LEAK_CTL, 8'h00);
        wr(slr_pkg::OFF_LEAK_CTL, 8'h01);
        wr(slr_pkg::OFF_LEAK_CTL, 8'h07);
        wr(slr_pkg::OFF_TRIM_LOW, 8'h33);
        rd(slr_pkg::OFF_LEAK_CTL, v);
        chk("locked_ctl", 8'h01, v & 8'h07);
        rd(slr_pkg::OFF_TRIM_LOW, v);
        chk("locked_low", 8'h01, {7'h0, v != 8'h33});
    endtask

    task automatic stop_test();
        if (miscompares == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        rst = 1'h1;
        {wr_stb, rd_stb, sleep_instr, wake_req, radio_off} = 5'h00;
        cmp_high = 1'h1;
        addr = 8'h00;
        wdata = 8'h00;
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        t_reset();
        t_deep();
        t_select();
        t_gates();
        t_trims();
        stop_test();
    end

    // Whole run is about 11000 cycles; allow generous slack
    initial
    begin
        repeat (60000) @(posedge clk);
        miscompares++;
        stop_test();
    end
endmodule

bind slr_sleep_power_ctrl slr_spc_assertions u_chk (.CORE_CLK, .RST, .ADDR, .WDATA,
    .WR_STB, .RD_STB, .RDATA, .SLEEP_INSTR, .WAKE_REQ, .RADIO_OFF, .CPU_SLEEP,
    .POWER_CHAIN_EN, .MAIN_REG_EN, .LEAK_REG_HOLD, .LEAK_TRIM_LOW, .LEAK_TRIM_HIGH,
    .GATE_TWO_WIRE, .GATE_CONVERTER);
